// [hdl/hfb_top.sv]
`timescale 1ns/1ns
module hfb_top (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // host register port
    input wire logic reg_addr_load_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [7:0] host_addr_ptr_out,
    // receive stream into the buffer
    input wire logic rx_valid_in,
    input wire logic [hfb_pkg::HFB_DATA_W-1:0] rx_data_in,
    output logic rx_ready_out,
    // interrupt event sources
    input wire logic [6:0] irq_request_first_event_in,
    input wire logic [6:0] irq_request_second_event_in,
    // status and control outputs
    output logic [6:0] irq_request_first_out,
    output logic [6:0] irq_request_second_out,
    output logic host_bus_select_out,
    output logic secure_module_bus_select_out,
    output logic sam_if_off_out,
    output logic sam_if_spi_out,
    output logic sam_if_i2cl_out,
    output logic sam_if_i2c_out,
    output logic buffer_empty_out,
    output logic buffer_full_out
);
    import hfb_pkg::*;

    logic [7:0] ptr_r, ptr_nxt;
    logic wr_en, rd_en;
    logic unlock_r, unlock_nxt, host_sel_r, host_sel_nxt, sam_sel_r, sam_sel_nxt;
    logic [1:0] if_type_r, if_type_nxt;
    logic depth_sel_r, depth_sel_nxt, wl8_r, wl8_nxt;
    logic [7:0] thresh_r, thresh_nxt;
    logic [6:0] irq_request_first_r, irq_request_first_nxt, irq_request_second_r, irq_request_second_nxt;
    logic hi_prev_r, lo_prev_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r;
    logic flush, host_push, host_pop, drain_ready, skid_valid, store_push;
    logic [HFB_DATA_W-1:0] skid_data, store_data, head_data;
    logic [HFB_CNT_W-1:0] count, limit, wl_eff, free_space;
    logic full, empty, hi_alert, lo_alert;

    // host access decode; a write and a read together count as the write
    always_comb begin
        wr_en = reg_wr_in;
        rd_en = reg_rd_in & ~reg_wr_in;
        ptr_nxt = ptr_r;
        if (reg_addr_load_in) begin
            ptr_nxt = reg_addr_in;
        end else if ((wr_en || rd_en) && ptr_r != HFB_ADDR_DATA) begin
            ptr_nxt = ptr_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ptr_r <= HFB_PTR_RST;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // bus access control, guarded by the one-shot unlock
    always_comb begin
        unlock_nxt = unlock_r;
        host_sel_nxt = host_sel_r;
        sam_sel_nxt = sam_sel_r;
        if_type_nxt = if_type_r;
        if (wr_en) begin
            if (unlock_r) begin
                unlock_nxt = 1'b0;
            end else if (ptr_r == HFB_ADDR_BAC && reg_wdata_in[HFB_BAC_UNLOCK]) begin
                unlock_nxt = 1'b1;
            end
            if (ptr_r == HFB_ADDR_BAC && unlock_r) begin
                if_type_nxt = reg_wdata_in[HFB_BAC_IF_LSB +: 2];
                // a request for both owners keeps the old owner
                if (!(reg_wdata_in[HFB_BAC_HOST] && reg_wdata_in[HFB_BAC_SAM])) begin
                    host_sel_nxt = reg_wdata_in[HFB_BAC_HOST];
                    sam_sel_nxt = reg_wdata_in[HFB_BAC_SAM];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            unlock_r <= 1'b0;
            host_sel_r <= HFB_BUS_SEL_RST[1];
            sam_sel_r <= HFB_BUS_SEL_RST[0];
            if_type_r <= HFB_IF_RST;
        end else begin
            unlock_r <= unlock_nxt;
            host_sel_r <= host_sel_nxt;
            sam_sel_r <= sam_sel_nxt;
            if_type_r <= if_type_nxt;
        end
    end

    always_comb begin
        host_bus_select_out = host_sel_r;
        secure_module_bus_select_out = sam_sel_r;
        sam_if_off_out = (if_type_r == HFB_IF_OFF);
        sam_if_spi_out = (if_type_r == HFB_IF_SPI);
        sam_if_i2cl_out = (if_type_r == HFB_IF_I2CL);
        sam_if_i2c_out = (if_type_r == HFB_IF_I2C);
    end

    // buffer configuration; depth changes with data inside are the host's problem
    always_comb begin
        depth_sel_nxt = depth_sel_r;
        wl8_nxt = wl8_r;
        thresh_nxt = thresh_r;
        flush = wr_en && ptr_r == HFB_ADDR_CTRL && reg_wdata_in[HFB_CTL_FLUSH];
        if (wr_en && ptr_r == HFB_ADDR_CTRL) begin
            depth_sel_nxt = reg_wdata_in[HFB_CTL_SIZE];
            wl8_nxt = reg_wdata_in[HFB_CTL_WL8];
        end
        if (wr_en && ptr_r == HFB_ADDR_THRESH) begin
            thresh_nxt = reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            depth_sel_r <= HFB_SIZE_RST;
            wl8_r <= 1'b0;
            thresh_r <= HFB_THRESH_RST;
        end else begin
            depth_sel_r <= depth_sel_nxt;
            wl8_r <= wl8_nxt;
            thresh_r <= thresh_nxt;
        end
    end

    // alerts and data path
    always_comb begin
        limit = depth_sel_r ? HFB_DEPTH_SMALL : HFB_DEPTH_LARGE;
        wl_eff = {1'b0, wl8_r & ~depth_sel_r, thresh_r};
        free_space = limit - count;
        hi_alert = (free_space <= wl_eff);
        lo_alert = (count <= wl_eff);
        host_push = wr_en && ptr_r == HFB_ADDR_DATA;
        host_pop = rd_en && ptr_r == HFB_ADDR_DATA;
        // host writes take the slot; the link word waits in the skid buffer
        drain_ready = ~full & ~host_push & ~flush;
        store_push = host_push | (skid_valid & drain_ready);
        store_data = host_push ? reg_wdata_in : skid_data;
        buffer_empty_out = empty;
        buffer_full_out = full;
    end

    hfb_skid2 #(
        .DATA_W(HFB_DATA_W),
        .DEPTH(2)
    ) u_skid (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(rx_valid_in),
        .in_data_in(rx_data_in),
        .in_ready_out(rx_ready_out),
        .out_valid_out(skid_valid),
        .out_data_out(skid_data),
        .out_ready_in(drain_ready)
    );

    // full drops pushes, empty drops pops inside the store
    hfb_store #(
        .DATA_W(HFB_DATA_W),
        .MEM_DEPTH(HFB_MEM_DEPTH),
        .CNT_W(HFB_CNT_W)
    ) u_store (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .flush_in(flush),
        .limit_in(limit),
        .push_in(store_push),
        .push_data_in(store_data),
        .pop_in(host_pop),
        .head_data_out(head_data),
        .count_out(count),
        .full_out(full),
        .empty_out(empty)
    );

    // interrupt requests; hardware events win over a same-cycle clear
    always_comb begin
        irq_request_first_nxt = irq_request_first_r;
        irq_request_second_nxt = irq_request_second_r;
        if (wr_en && ptr_r == HFB_ADDR_IRQ_REQUEST_FIRST) begin
            irq_request_first_nxt = reg_wdata_in[HFB_IRQ_SET] ? (irq_request_first_r | reg_wdata_in[6:0])
                                                 : (irq_request_first_r & ~reg_wdata_in[6:0]);
        end
        if (wr_en && ptr_r == HFB_ADDR_IRQ_REQUEST_SECOND) begin
            irq_request_second_nxt = reg_wdata_in[HFB_IRQ_SET] ? (irq_request_second_r | reg_wdata_in[6:0])
                                                 : (irq_request_second_r & ~reg_wdata_in[6:0]);
        end
        irq_request_first_nxt = irq_request_first_nxt | irq_request_first_event_in | {hi_alert & ~hi_prev_r, lo_alert & ~lo_prev_r, 5'h00};
        irq_request_second_nxt = irq_request_second_nxt | irq_request_second_event_in;
        irq_request_first_out = irq_request_first_r;
        irq_request_second_out = irq_request_second_r;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_request_first_r <= HFB_IRQ_RST;
            irq_request_second_r <= HFB_IRQ_RST;
            hi_prev_r <= 1'b0;
            lo_prev_r <= 1'b1; // buffer is empty at reset: no false low-alert edge
        end else begin
            irq_request_first_r <= irq_request_first_nxt;
            irq_request_second_r <= irq_request_second_nxt;
            hi_prev_r <= hi_alert;
            lo_prev_r <= lo_alert;
        end
    end

    // read-back mux; upper count bits are hidden in 255-byte mode, the wl8_r threshold bit still reads back
    always_comb begin
        case (ptr_r)
            HFB_ADDR_BAC: rdata_nxt = {unlock_r, host_sel_r, sam_sel_r, 1'b0, if_type_r, 2'h0};
            HFB_ADDR_CTRL: rdata_nxt = {depth_sel_r, hi_alert, lo_alert, 2'h0, wl8_r,
                                        count[9:8] & {2{~depth_sel_r}}};
            HFB_ADDR_THRESH: rdata_nxt = thresh_r;
            HFB_ADDR_FILL: rdata_nxt = count[7:0];
            HFB_ADDR_DATA: rdata_nxt = head_data;
            HFB_ADDR_IRQ_REQUEST_FIRST: rdata_nxt = {1'b0, irq_request_first_r};
            HFB_ADDR_IRQ_REQUEST_SECOND: rdata_nxt = {1'b0, irq_request_second_r};
            default: rdata_nxt = 8'h00;
        endcase
        reg_rdata_out = rdata_r;
        reg_rvalid_out = rvalid_r;
        host_addr_ptr_out = ptr_r;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rd_en ? rdata_nxt : rdata_r;
            rvalid_r <= rd_en;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_unlock_once;
        (wr_en && unlock_r) |=> !unlock_r;
    endproperty
    a_unlock_once: assert property (p_unlock_once) else $error("unlock survived a write");

    property p_sel_exclusive;
        !(host_bus_select_out && secure_module_bus_select_out);
    endproperty
    a_sel_exclusive: assert property (p_sel_exclusive) else $error("both bus selects set");

    property p_locked_stable;
        (wr_en && !unlock_r) |=> $stable({host_sel_r, sam_sel_r, if_type_r});
    endproperty
    a_locked_stable: assert property (p_locked_stable) else $error("locked control changed");

    property p_if_decode;
        $onehot({sam_if_off_out, sam_if_spi_out, sam_if_i2cl_out, sam_if_i2c_out})
            && (sam_if_i2cl_out == (if_type_r == 2'h2));
    endproperty
    a_if_decode: assert property (p_if_decode) else $error("interface decode wrong");

    property p_depth_limit;
        count <= (depth_sel_r ? 10'd255 : 10'd512);
    endproperty
    a_depth_limit: assert property (p_depth_limit) else $error("fill count beyond depth");

    property p_flush;
        flush |=> (count == '0) && buffer_empty_out;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left data");

    property p_push_count;
        (host_push && !full && !flush && !(host_pop && !empty)) |=> count == $past(count) + 10'd1;
    endproperty
    a_push_count: assert property (p_push_count) else $error("push did not count up");

    property p_pop_empty;
        (host_pop && empty && !store_push) |=> count == '0;
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("empty read changed count");

    property p_ptr_hold;
        ((wr_en || rd_en) && !reg_addr_load_in && ptr_r == HFB_ADDR_DATA) ##1 !reg_addr_load_in
            |-> host_addr_ptr_out == 8'h05;
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("data port moved the pointer");

    property p_irq_set;
        (wr_en && ptr_r == HFB_ADDR_IRQ_REQUEST_SECOND && reg_wdata_in[7]) |=>
            ((irq_request_second_out & $past(reg_wdata_in[6:0])) == $past(reg_wdata_in[6:0]));
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq set write missed");

    property p_lo_alert;
        (count == '0) |-> rdata_nxt[5] || ptr_r != HFB_ADDR_CTRL;
    endproperty
    a_lo_alert: assert property (p_lo_alert) else $error("low alert missing when empty");
endmodule : hfb_top

// [hdl/hfb_pkg.sv]
package hfb_pkg;
    // register addresses seen through the host address pointer
    localparam logic [7:0] HFB_ADDR_BAC = 8'h01;
    localparam logic [7:0] HFB_ADDR_CTRL = 8'h02;
    localparam logic [7:0] HFB_ADDR_THRESH = 8'h03;
    localparam logic [7:0] HFB_ADDR_FILL = 8'h04;
    localparam logic [7:0] HFB_ADDR_DATA = 8'h05;
    localparam logic [7:0] HFB_ADDR_IRQ_REQUEST_FIRST = 8'h06;
    localparam logic [7:0] HFB_ADDR_IRQ_REQUEST_SECOND = 8'h07;
    // bus_access_control fields
    localparam int HFB_BAC_UNLOCK = 7;
    localparam int HFB_BAC_HOST = 6;
    localparam int HFB_BAC_SAM = 5;
    localparam int HFB_BAC_IF_LSB = 2;
    // buffer_control fields
    localparam int HFB_CTL_SIZE = 7;
    localparam int HFB_CTL_HI = 6;
    localparam int HFB_CTL_LO = 5;
    localparam int HFB_CTL_FLUSH = 4;
    localparam int HFB_CTL_WL8 = 2;
    // interrupt request set/clear select
    localparam int HFB_IRQ_SET = 7;
    // secure module interface codes
    localparam logic [1:0] HFB_IF_OFF = 2'h0;
    localparam logic [1:0] HFB_IF_SPI = 2'h1;
    localparam logic [1:0] HFB_IF_I2CL = 2'h2;
    localparam logic [1:0] HFB_IF_I2C = 2'h3;
    // widths and depths
    localparam int HFB_DATA_W = 8;
    localparam int HFB_CNT_W = 10;
    localparam int HFB_MEM_DEPTH = 512;
    localparam logic [9:0] HFB_DEPTH_SMALL = 10'h0FF;
    localparam logic [9:0] HFB_DEPTH_LARGE = 10'h200;
    // reset values
    localparam logic [1:0] HFB_BUS_SEL_RST = 2'h2;
    localparam logic [1:0] HFB_IF_RST = 2'h0;
    localparam logic HFB_SIZE_RST = 1'b0;
    localparam logic [7:0] HFB_THRESH_RST = 8'h00;
    localparam logic [6:0] HFB_IRQ_RST = 7'h00;
    localparam logic [7:0] HFB_PTR_RST = 8'h00;
endpackage : hfb_pkg

// [hdl/hfb_skid2.sv]
`timescale 1ns/1ns
module hfb_skid2 #(
    parameter int DATA_W = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // filling side
    input wire logic in_valid_in,
    input wire logic [DATA_W-1:0] in_data_in,
    output logic in_ready_out,
    // draining side
    output logic out_valid_out,
    output logic [DATA_W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("hfb_skid2: DEPTH must be a power of two, at least 2");
    end

    logic [DATA_W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic do_in, do_out;

    always_comb begin
        in_ready_out = (cnt_r != (AW+1)'(DEPTH));
        out_valid_out = (cnt_r != '0);
        out_data_out = mem_r[rp_r];
        do_in = in_valid_in & in_ready_out;
        do_out = out_valid_out & out_ready_in;
        wp_nxt = do_in ? wp_r + 1'b1 : wp_r;
        rp_nxt = do_out ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(do_in) - (AW+1)'(do_out);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage holds no control state, so it needs no reset
    always_ff @(posedge sys_clk_in) begin
        if (do_in) begin
            mem_r[wp_r] <= in_data_in;
        end
    end
endmodule : hfb_skid2

// [hdl/hfb_store.sv]
`timescale 1ns/1ns
module hfb_store #(
    parameter int DATA_W = 8,
    parameter int MEM_DEPTH = 512,
    parameter int CNT_W = 10
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // control
    input wire logic flush_in,
    input wire logic [CNT_W-1:0] limit_in,
    // push and pop
    input wire logic push_in,
    input wire logic [DATA_W-1:0] push_data_in,
    input wire logic pop_in,
    // state
    output logic [DATA_W-1:0] head_data_out,
    output logic [CNT_W-1:0] count_out,
    output logic full_out,
    output logic empty_out
);
    localparam int AW = $clog2(MEM_DEPTH);

    if ((1 << AW) != MEM_DEPTH || (1 << CNT_W) <= MEM_DEPTH) begin : g_bad_size
        $error("hfb_store: MEM_DEPTH must be a power of two below 2**CNT_W");
    end

    logic [DATA_W-1:0] mem_r [MEM_DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    always_comb begin
        full_out = (cnt_r >= limit_in);
        empty_out = (cnt_r == '0);
        count_out = cnt_r;
        head_data_out = mem_r[rp_r];
        do_push = push_in & ~full_out;
        do_pop = pop_in & ~empty_out;
        if (flush_in) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end else begin
            wp_nxt = do_push ? wp_r + 1'b1 : wp_r;
            rp_nxt = do_pop ? rp_r + 1'b1 : rp_r;
            cnt_nxt = cnt_r + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (do_push && !flush_in) begin
            mem_r[wp_r] <= push_data_in;
        end
    end
endmodule : hfb_store

// [tb/hfb_link_src.sv]
`timescale 1ns/1ns
module hfb_link_src (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // stream towards the block
    input wire logic rx_ready_in,
    output logic rx_valid_out,
    output logic [hfb_pkg::HFB_DATA_W-1:0] rx_data_out
);
    import hfb_pkg::*;
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'hA5;
    end
    // words go out in order, each held until the block takes it
    task send(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk_in);
            rx_valid_out = 1'b1;
            rx_data_out = base + i[7:0];
            // ready does not depend on valid, so it is settled here
            while (rx_ready_in !== 1'b1) @(negedge sys_clk_in);
            @(posedge sys_clk_in);
        end
        @(negedge sys_clk_in);
        rx_valid_out = 1'b0;
        // released line shows the inverse, never a stale word
        rx_data_out = ~rx_data_out;
    endtask : send
endmodule : hfb_link_src

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
    import hfb_pkg::*;
    logic clk, rst_b, ld, wr, rd, rvalid, ready, valid;
    logic [7:0] addr, wdata, rdata, ptr, rxd, q;
    logic [6:0] irq_request_first, irq_request_second, ev1;
    logic hsel, ssel, f_off, f_spi, f_i2cl, f_i2c, empty, full;
    int n_errors = 0;
    int samples_checked = 0;

    hfb_top i_dut (
        .sys_clk_in(clk), .rst_b_in(rst_b),
        .reg_addr_load_in(ld), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .host_addr_ptr_out(ptr), .rx_valid_in(valid), .rx_data_in(rxd), .rx_ready_out(ready),
        .irq_request_first_event_in(7'h00), .irq_request_second_event_in(ev1),
        .irq_request_first_out(irq_request_first), .irq_request_second_out(irq_request_second),
        .host_bus_select_out(hsel), .secure_module_bus_select_out(ssel),
        .sam_if_off_out(f_off), .sam_if_spi_out(f_spi), .sam_if_i2cl_out(f_i2cl),
        .sam_if_i2c_out(f_i2c), .buffer_empty_out(empty), .buffer_full_out(full)
    );

    hfb_link_src i_src (
        .sys_clk_in(clk), .rst_b_in(rst_b),
        .rx_ready_in(ready), .rx_valid_out(valid), .rx_data_out(rxd)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk8

    // optional pointer load, then one strobe; read data taken with rvalid
    task acc(input bit l, input bit w, input logic [7:0] a, input logic [7:0] d);
        if (l) begin
            ld = 1'b1;
            addr = a;
            @(negedge clk);
            ld = 1'b0;
        end else begin
            // let an edge pass so a strobe is never lowered and raised in one step
            @(negedge clk);
        end
        if (w) begin
            wr = 1'b1;
            wdata = d;
        end else begin
            rd = 1'b1;
        end
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        q = (!w && rvalid === 1'b1) ? rdata : 8'hXX;
    endtask : acc

    task wreg(input logic [7:0] a, input logic [7:0] d);
        acc(1, 1, a, d);
    endtask : wreg

    task rreg(input logic [7:0] a, input logic [7:0] e);
        acc(1, 0, a, 8'h00);
        chk8(q, e);
    endtask : rreg

    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end

    initial begin
        rst_b = 1'b0;
        {ld, wr, rd} = 3'b000;
        addr = 8'h00;
        wdata = 8'h00;
        ev1 = 7'h00;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        rreg(HFB_ADDR_BAC, 8'h40);
        rreg(HFB_ADDR_CTRL, 8'h20);
        rreg(HFB_ADDR_THRESH, 8'h00);
        chk8(ptr, 8'h04);
        rreg(HFB_ADDR_FILL, 8'h00);
        rreg(HFB_ADDR_IRQ_REQUEST_SECOND, 8'h00);
        rreg(HFB_ADDR_IRQ_REQUEST_FIRST, 8'h00);
        wreg(HFB_ADDR_BAC, 8'h20);
        rreg(HFB_ADDR_BAC, 8'h40);
        wreg(HFB_ADDR_BAC, 8'h80);
        wreg(HFB_ADDR_BAC, 8'h24);
        rreg(HFB_ADDR_BAC, 8'h24);
        chk8({6'h00, hsel, ssel}, 8'h01);
        wreg(HFB_ADDR_BAC, 8'h28);
        rreg(HFB_ADDR_BAC, 8'h24);
        wreg(HFB_ADDR_BAC, 8'h80);
        wreg(HFB_ADDR_BAC, 8'h6C);
        rreg(HFB_ADDR_BAC, 8'h2C);
        for (int k = 0; k < 4; k++) begin
            wreg(HFB_ADDR_BAC, 8'h80);
            wreg(HFB_ADDR_BAC, 8'h40 | (k[7:0] << 2));
            chk8({4'h0, f_off, f_spi, f_i2cl, f_i2c}, 8'h08 >> k);
        end
        // threshold 2, three bytes in, 512 mode
        wreg(HFB_ADDR_THRESH, 8'h02);
        acc(1, 1, HFB_ADDR_DATA, 8'hA1);
        acc(0, 1, 8'h00, 8'hA2);
        acc(0, 1, 8'h00, 8'hA3);
        chk8(ptr, HFB_ADDR_DATA);
        rreg(HFB_ADDR_FILL, 8'h03);
        rreg(HFB_ADDR_CTRL, 8'h00);
        wreg(HFB_ADDR_CTRL, 8'h04);
        rreg(HFB_ADDR_CTRL, 8'h24);
        rreg(HFB_ADDR_DATA, 8'hA1);
        rreg(HFB_ADDR_FILL, 8'h02);
        wreg(HFB_ADDR_CTRL, 8'h14);
        rreg(HFB_ADDR_CTRL, 8'h24);
        acc(1, 0, HFB_ADDR_DATA, 8'h00);
        chk8(ptr, HFB_ADDR_DATA);
        rreg(HFB_ADDR_FILL, 8'h00);
        // 258 bytes reach count bits 9:8; threshold now 258
        i_src.send(258, 8'h10);
        repeat (4) @(negedge clk);
        rreg(HFB_ADDR_FILL, 8'h02);
        rreg(HFB_ADDR_CTRL, 8'h65);
        // depth changed together with a flush so the buffer is empty
        wreg(HFB_ADDR_CTRL, 8'h90);
        i_src.send(257, 8'h00);
        repeat (2) @(negedge clk);
        chk8({6'h00, ready, full}, 8'h01);
        rreg(HFB_ADDR_CTRL, 8'hC0);
        acc(1, 1, HFB_ADDR_DATA, 8'h55);
        rreg(HFB_ADDR_FILL, 8'hFF);
        acc(1, 0, HFB_ADDR_DATA, 8'h00);
        chk8(q, 8'h00);
        for (int i = 1; i < 257; i++) begin
            acc(0, 0, 8'h00, 8'h00);
            chk8(q, i[7:0]);
        end
        repeat (2) @(negedge clk);
        rreg(HFB_ADDR_FILL, 8'h00);
        chk8({7'h00, empty}, 8'h01);
        // alert edges from the buffer tests are cleared first
        wreg(HFB_ADDR_IRQ_REQUEST_FIRST, 8'h7F);
        rreg(HFB_ADDR_IRQ_REQUEST_FIRST, 8'h00);
        wreg(HFB_ADDR_IRQ_REQUEST_FIRST, 8'h85);
        rreg(HFB_ADDR_IRQ_REQUEST_FIRST, 8'h05);
        wreg(HFB_ADDR_IRQ_REQUEST_FIRST, 8'h03);
        chk8({1'b0, irq_request_first} & 8'h1F, 8'h04);
        wreg(HFB_ADDR_IRQ_REQUEST_SECOND, 8'hFF);
        rreg(HFB_ADDR_IRQ_REQUEST_SECOND, 8'h7F);
        wreg(HFB_ADDR_IRQ_REQUEST_SECOND, 8'h7F);
        rreg(HFB_ADDR_IRQ_REQUEST_SECOND, 8'h00);
        ev1 = 7'h08;
        @(negedge clk);
        ev1 = 7'h00;
        chk8({1'b0, irq_request_second}, 8'h08);
        end_of_test();
    end
endmodule : tb
